// [bcp_consts.svh]
`ifndef BCP_CONSTS_SVH
`define BCP_CONSTS_SVH

// register byte offsets
`define BCP_OFS_CDB0       6'h00
`define BCP_OFS_CDB1       6'h04
`define BCP_OFS_CDB2       6'h08
`define BCP_OFS_CTRL       6'h0c
`define BCP_OFS_STAT       6'h10
`define BCP_OFS_LAST_LBA   6'h14
`define BCP_OFS_BLK_LEN    6'h18
`define BCP_OFS_POWER      6'h1c

// field positions
`define BCP_CTRL_GO_BIT    0

// reset values and low-power threshold of the power setting
`define BCP_RST_LAST_LBA   32'h0000_0000
`define BCP_RST_BLK_LEN    32'h0000_0200
`define BCP_RST_PP         8'h00
`define BCP_PP_LOW_MIN     8'h80

// operation codes
`define BCP_OP_READ10      8'h28
`define BCP_OP_READ_CAP    8'h25
`define BCP_OP_START_STOP  8'h1b

// status and sense codes
`define BCP_ST_GOOD        8'h00
`define BCP_ST_CHECK       8'h02
`define BCP_SK_NONE        8'h00
`define BCP_SK_NOT_READY   8'h02
`define BCP_SK_ILLEGAL     8'h05
`define BCP_ASC_NOT_READY  8'h04
`define BCP_ASC_BAD_OP     8'h20
`define BCP_ASC_BAD_FIELD  8'h24
`define BCP_ASC_LOW_POWER  8'h5e
`define BCP_ASCQ_NONE      8'h00
`define BCP_ASCQ_STOPPED   8'h02

// power condition codes
`define BCP_PC_NONE        4'h0
`define BCP_PC_ACTIVE      4'h1
`define BCP_PC_STANDBY     4'h3
`define BCP_PC_SLEEP       4'h5
`define BCP_PC_DEVCTL      4'h7

`define BCP_CAP_BYTES      4'h8

`endif

// [bcp_pkg.sv]
package bcp_pkg;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_DECODE   = 4'b0001,
      ST_RD_FETCH = 4'b0010,
      ST_RD_WAIT  = 4'b0011,
      ST_RD_LATCH = 4'b0100,
      ST_RD_SEND  = 4'b0101,
      ST_CAP_SEND = 4'b0110,
      ST_PWR      = 4'b0111
   } bcp_state_type;

   typedef enum logic [1:0] {
      PW_IDLE  = 2'b00,
      PW_FLUSH = 2'b01,
      PW_DONE  = 2'b10
   } bcp_pwr_state_type;

endpackage

// [bcp_power.sv]
`timescale 1ns/1ns
`include "bcp_consts.svh"

module bcp_power
   import bcp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       req,
   input  wire logic [3:0] req_code,
   input  wire logic       flush_done,
   output logic            flush_req,
   output logic            done,
   output logic [3:0]      cond
);

   bcp_pwr_state_type state_reg, state_next;
   logic [3:0]        cond_reg, cond_next, code_reg, code_next;
   logic              flush_reg, flush_next, done_reg, done_next;

   always_comb begin
      state_next = state_reg;
      cond_next  = cond_reg;
      code_next  = code_reg;
      flush_next = flush_reg;
      done_next  = 1'b0;
      unique case (state_reg)
         PW_IDLE: begin
            if (req) begin
               code_next = req_code;
               // dirty cache goes to the medium before standby or sleep [R14]
               if (req_code == `BCP_PC_STANDBY || req_code == `BCP_PC_SLEEP) begin
                  flush_next = 1'b1;
                  state_next = PW_FLUSH;
               end else begin
                  state_next = PW_DONE;
               end
            end
         end
         PW_FLUSH: begin
            if (flush_done) begin
               flush_next = 1'b0;
               state_next = PW_DONE;
            end
         end
         PW_DONE: begin
            // same condition again is simply taken [R18]
            cond_next  = code_reg; // [R13]
            done_next  = 1'b1;
            state_next = PW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= PW_IDLE;
         cond_reg  <= `BCP_PC_ACTIVE;
         code_reg  <= `BCP_PC_NONE;
         flush_reg <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cond_reg  <= cond_next;
         code_reg  <= code_next;
         flush_reg <= flush_next;
         done_reg  <= done_next;
      end
   end

   assign flush_req = flush_reg;
   assign done      = done_reg;
   assign cond      = cond_reg;

endmodule // bcp_power

// [bcp_cmd.sv]
// Operation
// (R1) read command 28h returns newest block data
// (R2) address field names first block read
// (R3) transfer exactly length blocks; zero is good
// (R4) initiator packs address and length big-endian
// (R5) capacity command 25h reports current capacity
// (R6) capacity data precedes good status
// (R7) last address then block length, MSB first
// (R8) no medium: check, not ready, 04h
// (R9) start/stop 1Bh sets access and power
// (R10) initiator places immed, power, loej, start
// (R11) immed gives status early, else after
// (R12) nonzero power condition ignores start and loej
// (R13) decode power codes; reserved codes rejected
// (R14) flush cache before standby or sleep
// (R15) initiator may need reset after sleep
// (R16) device-controlled level limited by setting
// (R17) too much power: check, 05h, 5Eh/00h
// (R18) same power condition again is no error
// (R19) start bit stops or readies the unit
// (R20) loej with start loads, without ejects
// (R21) initiator sets control byte to zero
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "bcp_consts.svh"

module bcp_cmd
   import bcp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        medium_present,
   output logic [7:0]       media_lba_hi,
   output logic [31:0]      media_lba,
   output logic [31:0]      media_offset,
   output logic             media_rd_en,
   input  wire logic [7:0]  media_rd_data,
   output logic [7:0]       data_byte,
   output logic             data_valid,
   input  wire logic        data_ready,
   output logic             status_valid,
   output logic [7:0]       status_code,
   output logic             flush_req,
   input  wire logic        flush_done,
   output logic             eject_pulse,
   output logic             load_pulse,
   output logic             unit_ready,
   output logic [3:0]       power_cond
);

   function automatic logic [31:0] wr_mask(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchroniser
   logic med_meta_reg, med_sync_reg;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         med_meta_reg <= 1'b0;
         med_sync_reg <= 1'b0;
      end else begin
         med_meta_reg <= medium_present;
         med_sync_reg <= med_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state
   bcp_state_type state_reg, state_next;
   logic [31:0] cdb0_reg, cdb0_next, cdb1_reg, cdb1_next, cdb2_reg, cdb2_next;
   logic [31:0] last_lba_reg, last_lba_next, blk_len_reg, blk_len_next;
   logic [7:0]  pp_reg, pp_next;
   logic [31:0] rdat_reg, rdat_next;
   logic        ack_reg, ack_next, done_reg, done_next, ready_reg, ready_next;
   logic [31:0] lba_reg, lba_next, off_reg, off_next;
   logic [15:0] blk_cnt_reg, blk_cnt_next;
   logic [63:0] shift_reg, shift_next;
   logic [3:0]  cap_cnt_reg, cap_cnt_next;
   logic [7:0]  dbyte_reg, dbyte_next;
   logic        dval_reg, dval_next, rden_reg, rden_next, stv_reg, stv_next;
   logic [7:0]  st_reg, st_next, sk_reg, sk_next, asc_reg, asc_next, ascq_reg, ascq_next;
   logic        immed_reg, immed_next, ej_reg, ej_next, ld_reg, ld_next;
   logic        pwr_req, pwr_done;
   logic [3:0]  pwr_code, cond;

   // fields of the latched command block
   logic [7:0]  opcode, cdb4;
   logic [31:0] cdb_lba;
   logic [15:0] cdb_len;
   logic [3:0]  cdb_pc;
   logic        low_power, busy, wb_req, go_wr;

   assign opcode   = cdb0_reg[7:0];
   assign cdb_lba  = {cdb0_reg[23:16], cdb0_reg[31:24], cdb1_reg[7:0], cdb1_reg[15:8]}; // [R2]
   assign cdb_len  = {cdb1_reg[31:24], cdb2_reg[7:0]}; // [R3]
   assign cdb4     = cdb1_reg[7:0];
   assign cdb_pc   = cdb4[7:4];
   assign pwr_code = cdb_pc;

   // device-controlled mode borrows the setting to decide how low it may go
   assign low_power = (cond == `BCP_PC_STANDBY) || (cond == `BCP_PC_SLEEP) ||
                      (cond == `BCP_PC_DEVCTL && pp_reg >= `BCP_PP_LOW_MIN); // [R16]
   assign busy      = (state_reg != ST_IDLE);
   assign wb_req    = wb_cyc_i && wb_stb_i && !ack_reg;
   assign go_wr     = wb_req && wb_we_i && wb_adr_i == `BCP_OFS_CTRL && wb_sel_i[0] &&
                      wb_dat_i[`BCP_CTRL_GO_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      state_next    = state_reg;
      cdb0_next     = cdb0_reg;
      cdb1_next     = cdb1_reg;
      cdb2_next     = cdb2_reg;
      last_lba_next = last_lba_reg;
      blk_len_next  = blk_len_reg;
      pp_next       = pp_reg;
      rdat_next     = 32'h0000_0000;
      ack_next      = wb_req;
      done_next     = done_reg;
      ready_next    = ready_reg;
      lba_next      = lba_reg;
      off_next      = off_reg;
      blk_cnt_next  = blk_cnt_reg;
      shift_next    = shift_reg;
      cap_cnt_next  = cap_cnt_reg;
      dbyte_next    = dbyte_reg;
      dval_next     = dval_reg;
      rden_next     = 1'b0;
      stv_next      = 1'b0;
      st_next       = st_reg;
      sk_next       = sk_reg;
      asc_next      = asc_reg;
      ascq_next     = ascq_reg;
      immed_next    = immed_reg;
      ej_next       = 1'b0;
      ld_next       = 1'b0;
      pwr_req       = 1'b0;

      // bus slave: one wait state, unmapped reads give zero, unmapped writes drop
      if (wb_req && wb_we_i && !busy) begin
         unique case (wb_adr_i)
            `BCP_OFS_CDB0:     cdb0_next     = wr_mask(cdb0_reg, wb_dat_i, wb_sel_i);
            `BCP_OFS_CDB1:     cdb1_next     = wr_mask(cdb1_reg, wb_dat_i, wb_sel_i);
            `BCP_OFS_CDB2:     cdb2_next     = wr_mask(cdb2_reg, wb_dat_i, wb_sel_i);
            `BCP_OFS_LAST_LBA: last_lba_next = wr_mask(last_lba_reg, wb_dat_i, wb_sel_i);
            `BCP_OFS_BLK_LEN:  blk_len_next  = wr_mask(blk_len_reg, wb_dat_i, wb_sel_i);
            `BCP_OFS_POWER:    if (wb_sel_i[1]) pp_next = wb_dat_i[15:8];
            default: ;
         endcase
      end
      if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            `BCP_OFS_CDB0:     rdat_next = cdb0_reg;
            `BCP_OFS_CDB1:     rdat_next = cdb1_reg;
            `BCP_OFS_CDB2:     rdat_next = cdb2_reg;
            `BCP_OFS_CTRL:     rdat_next = {28'h0000_000, med_sync_reg, ready_reg, done_reg,
                                            busy || stv_reg};
            `BCP_OFS_STAT:     rdat_next = {ascq_reg, asc_reg, sk_reg, st_reg};
            `BCP_OFS_LAST_LBA: rdat_next = last_lba_reg;
            `BCP_OFS_BLK_LEN:  rdat_next = blk_len_reg;
            `BCP_OFS_POWER:    rdat_next = {16'h0000, pp_reg, 4'h0, cond};
            default:           rdat_next = 32'h0000_0000;
         endcase
      end

      unique case (state_reg)
         ST_IDLE: begin
            // go while busy is ignored
            if (go_wr) begin
               done_next  = 1'b0;
               state_next = ST_DECODE;
            end
         end
         ST_DECODE: begin
            stv_next   = 1'b1;
            st_next    = `BCP_ST_CHECK;
            sk_next    = `BCP_SK_ILLEGAL;
            asc_next   = `BCP_ASC_BAD_OP;
            ascq_next  = `BCP_ASCQ_NONE;
            state_next = ST_IDLE;
            unique case (opcode)
               `BCP_OP_READ10: begin
                  if (!med_sync_reg || !ready_reg) begin
                     sk_next   = `BCP_SK_NOT_READY;
                     asc_next  = `BCP_ASC_NOT_READY;
                     ascq_next = med_sync_reg ? `BCP_ASCQ_STOPPED : `BCP_ASCQ_NONE;
                  end else if (low_power) begin
                     asc_next = `BCP_ASC_LOW_POWER; // [R17]
                  end else if (cdb_len == 16'h0000) begin
                     st_next  = `BCP_ST_GOOD; // [R3]
                     sk_next  = `BCP_SK_NONE;
                     asc_next = `BCP_ASCQ_NONE;
                  end else begin
                     stv_next     = 1'b0;
                     lba_next     = cdb_lba; // [R2]
                     off_next     = 32'h0000_0000;
                     blk_cnt_next = cdb_len;
                     state_next   = ST_RD_FETCH; // [R1]
                  end
               end
               `BCP_OP_READ_CAP: begin
                  if (!med_sync_reg) begin
                     sk_next   = `BCP_SK_NOT_READY; // [R8]
                     asc_next  = `BCP_ASC_NOT_READY;
                     ascq_next = ready_reg ? `BCP_ASCQ_NONE : `BCP_ASCQ_STOPPED;
                  end else if (cond == `BCP_PC_SLEEP) begin
                     asc_next = `BCP_ASC_LOW_POWER; // [R17]
                  end else begin
                     stv_next     = 1'b0;
                     dbyte_next   = last_lba_reg[31:24]; // [R7]
                     dval_next    = 1'b1;
                     shift_next   = {last_lba_reg[23:0], blk_len_reg, 8'h00};
                     cap_cnt_next = `BCP_CAP_BYTES;
                     state_next   = ST_CAP_SEND; // [R5]
                  end
               end
               `BCP_OP_START_STOP: begin
                  st_next  = `BCP_ST_GOOD; // [R9]
                  sk_next  = `BCP_SK_NONE;
                  asc_next = `BCP_ASCQ_NONE;
                  if (cdb_pc == 4'h4 || cdb_pc == 4'h6 || cdb_pc[3]) begin
                     st_next  = `BCP_ST_CHECK; // [R13]
                     sk_next  = `BCP_SK_ILLEGAL;
                     asc_next = `BCP_ASC_BAD_FIELD;
                  end else if (cdb_pc != `BCP_PC_NONE) begin
                     // start and loej play no part here [R12]
                     pwr_req    = 1'b1;
                     immed_next = cdb0_reg[8];
                     stv_next   = cdb0_reg[8]; // [R11]
                     state_next = ST_PWR;
                  end else begin
                     ready_next = cdb4[0]; // [R19]
                     ej_next    = cdb4[1] && !cdb4[0]; // [R20]
                     ld_next    = cdb4[1] && cdb4[0]; // [R20]
                  end
               end
               default: ;
            endcase
         end
         ST_RD_FETCH: begin
            rden_next  = 1'b1;
            state_next = ST_RD_WAIT;
         end
         ST_RD_WAIT: begin
            state_next = ST_RD_LATCH;
         end
         ST_RD_LATCH: begin
            dbyte_next = media_rd_data; // [R1]
            dval_next  = 1'b1;
            state_next = ST_RD_SEND;
         end
         ST_RD_SEND: begin
            if (data_ready) begin
               dval_next  = 1'b0;
               off_next   = off_reg + 32'h0000_0001;
               state_next = ST_RD_FETCH;
               if (off_reg == blk_len_reg - 32'h0000_0001) begin
                  off_next     = 32'h0000_0000;
                  lba_next     = lba_reg + 32'h0000_0001; // [R2]
                  blk_cnt_next = blk_cnt_reg - 16'h0001;
                  if (blk_cnt_reg == 16'h0001) begin
                     stv_next   = 1'b1; // [R3]
                     st_next    = `BCP_ST_GOOD;
                     sk_next    = `BCP_SK_NONE;
                     asc_next   = `BCP_ASCQ_NONE;
                     ascq_next  = `BCP_ASCQ_NONE;
                     state_next = ST_IDLE;
                  end
               end
            end
         end
         ST_CAP_SEND: begin
            if (data_ready) begin
               dbyte_next   = shift_reg[63:56];
               shift_next   = {shift_reg[55:0], 8'h00};
               cap_cnt_next = cap_cnt_reg - 4'h1;
               if (cap_cnt_reg == 4'h1) begin
                  // status only after the last capacity byte is taken [R6]
                  dval_next  = 1'b0;
                  stv_next   = 1'b1;
                  st_next    = `BCP_ST_GOOD;
                  sk_next    = `BCP_SK_NONE;
                  asc_next   = `BCP_ASCQ_NONE;
                  ascq_next  = `BCP_ASCQ_NONE;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_PWR: begin
            if (pwr_done) begin
               stv_next   = !immed_reg; // [R11]
               state_next = ST_IDLE;
            end
         end
      endcase
      if (stv_next) begin
         done_next = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg    <= ST_IDLE;
         cdb0_reg     <= 32'h0000_0000;
         cdb1_reg     <= 32'h0000_0000;
         cdb2_reg     <= 32'h0000_0000;
         last_lba_reg <= `BCP_RST_LAST_LBA;
         blk_len_reg  <= `BCP_RST_BLK_LEN;
         pp_reg       <= `BCP_RST_PP;
         rdat_reg     <= 32'h0000_0000;
         ack_reg      <= 1'b0;
         done_reg     <= 1'b0;
         ready_reg    <= 1'b1;
         lba_reg      <= 32'h0000_0000;
         off_reg      <= 32'h0000_0000;
         blk_cnt_reg  <= 16'h0000;
         shift_reg    <= 64'h0000_0000_0000_0000;
         cap_cnt_reg  <= 4'h0;
         dbyte_reg    <= 8'h00;
         dval_reg     <= 1'b0;
         rden_reg     <= 1'b0;
         stv_reg      <= 1'b0;
         st_reg       <= `BCP_ST_GOOD;
         sk_reg       <= `BCP_SK_NONE;
         asc_reg      <= `BCP_ASCQ_NONE;
         ascq_reg     <= `BCP_ASCQ_NONE;
         immed_reg    <= 1'b0;
         ej_reg       <= 1'b0;
         ld_reg       <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cdb0_reg     <= cdb0_next;
         cdb1_reg     <= cdb1_next;
         cdb2_reg     <= cdb2_next;
         last_lba_reg <= last_lba_next;
         blk_len_reg  <= blk_len_next;
         pp_reg       <= pp_next;
         rdat_reg     <= rdat_next;
         ack_reg      <= ack_next;
         done_reg     <= done_next;
         ready_reg    <= ready_next;
         lba_reg      <= lba_next;
         off_reg      <= off_next;
         blk_cnt_reg  <= blk_cnt_next;
         shift_reg    <= shift_next;
         cap_cnt_reg  <= cap_cnt_next;
         dbyte_reg    <= dbyte_next;
         dval_reg     <= dval_next;
         rden_reg     <= rden_next;
         stv_reg      <= stv_next;
         st_reg       <= st_next;
         sk_reg       <= sk_next;
         asc_reg      <= asc_next;
         ascq_reg     <= ascq_next;
         immed_reg    <= immed_next;
         ej_reg       <= ej_next;
         ld_reg       <= ld_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power condition keeper
   bcp_power u_power (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .req        (pwr_req),
      .req_code   (pwr_code),
      .flush_done (flush_done),
      .flush_req  (flush_req),
      .done       (pwr_done),
      .cond       (cond)
   );

   assign wb_dat_o     = rdat_reg;
   assign wb_ack_o     = ack_reg;
   assign media_lba_hi = 8'h00;
   assign media_lba    = lba_reg;
   assign media_offset = off_reg;
   assign media_rd_en  = rden_reg;
   assign data_byte    = dbyte_reg;
   assign data_valid   = dval_reg;
   assign status_valid = stv_reg;
   assign status_code  = st_reg;
   assign eject_pulse  = ej_reg;
   assign load_pulse   = ld_reg;
   assign unit_ready   = ready_reg;
   assign power_cond   = cond;

endmodule // bcp_cmd

// [bcp_far_model.sv]
`timescale 1ns/1ns
module bcp_far_model (
   input  wire logic        clk_sys,
   input  wire logic        media_rd_en,
   input  wire logic [31:0] media_lba,
   input  wire logic [31:0] media_offset,
   input  wire logic        flush_req,
   output logic       [7:0] media_rd_data,
   output logic             flush_done,
   output logic             data_ready
);
   logic [1:0] cnt_reg;
   logic [3:0] fcnt_reg;
   logic       hold_reg;
   initial begin
      {cnt_reg, fcnt_reg, hold_reg, media_rd_data, flush_done, data_ready} = '0;
   end
   always @(posedge clk_sys) begin
      cnt_reg <= cnt_reg + 2'h1;
      hold_reg <= media_rd_en;
      // ready drops one cycle in four
      data_ready <= (cnt_reg != 2'h3);
      if (media_rd_en)
         media_rd_data <= media_lba[7:0] ^ {media_offset[3:0], 4'h0};
      else if (!hold_reg)
         media_rd_data <= ~media_rd_data;
      // slow flush tells early status from late
      fcnt_reg <= flush_req ? fcnt_reg + 4'h1 : 4'h0;
      flush_done <= flush_req && fcnt_reg == 4'hf;
   end
endmodule // bcp_far_model

// [bcp_cmd_props.sv]
`timescale 1ns/1ns
`include "bcp_consts.svh"
module bcp_cmd_props
   import bcp_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       data_valid,
   input wire logic       data_ready,
   input wire logic [7:0] data_byte,
   input wire logic       status_valid,
   input wire logic       flush_req,
   input wire logic       flush_done,
   input wire logic       eject_pulse,
   input wire logic       load_pulse,
   input wire logic       unit_ready,
   input wire logic [3:0] power_cond
);
   logic fl_reg, fl_next;
   logic [3:0] pc_reg;
   always_comb begin
      fl_next = fl_reg;
      if (flush_req && flush_done)
         fl_next = 1'b1;
      else if (power_cond != pc_reg)
         fl_next = 1'b0;
   end
   always_ff @(posedge clk_sys) begin
      fl_reg <= rst ? 1'b0 : fl_next;
      pc_reg <= rst ? `BCP_PC_ACTIVE : power_cond;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not one pulse");
   chk_flush_first: assert property (power_cond != pc_reg && power_cond inside {3, 5} |-> fl_reg)
      else $error("flush missing");
   chk_flush_hold: assert property (flush_req && !flush_done |=> flush_req)
      else $error("flush dropped early");
   chk_pc_legal: assert property (power_cond != pc_reg |-> power_cond inside {1, 2, 3, 5, 7})
      else $error("reserved power code");
   chk_byte_hold: assert property (data_valid && !data_ready |=> data_valid && $stable(data_byte))
      else $error("byte not held");
   chk_data_first: assert property (status_valid |-> !data_valid)
      else $error("status with data");
   chk_eject_stop: assert property (eject_pulse |-> status_valid && !load_pulse ##1 !unit_ready)
      else $error("eject without stop");
   chk_load_ready: assert property (load_pulse |-> status_valid ##1 unit_ready)
      else $error("load not ready");
   chk_status_once: assert property (status_valid |=> !status_valid)
      else $error("status not one pulse");
endmodule // bcp_cmd_props
bind bcp_cmd bcp_cmd_props bcp_cmd_props_i (.*);

// [testbench.sv]
`timescale 1ns/1ns
`include "bcp_consts.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
   logic        clk_sys = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic        medium_present = 1, wb_ack_o, media_rd_en, data_valid, data_ready;
   logic        status_valid, flush_req, flush_done, eject_pulse, load_pulse, unit_ready;
   logic [5:0]  wb_adr_i = 0;
   logic [3:0]  wb_sel_i = 0, power_cond;
   logic [31:0] wb_dat_i = 0, wb_dat_o, media_lba, media_offset, rv;
   logic [7:0]  media_lba_hi, media_rd_data, data_byte, status_code;
   logic [7:0]  q[$];
   logic        st_seen;
   int          miscompares = 0, check_count = 0, ej = 0, ld = 0, fl = 0;
   bcp_cmd bcp_cmd_i (.*);
   bcp_far_model bcp_far_model_i (.*);
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (status_valid) st_seen = 1'b1;
      if (data_valid && data_ready) q.push_back(data_byte);
      if (eject_pulse) ej++;
      if (load_pulse) ld++;
      if (flush_req && flush_done) fl++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
      int n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
      do begin @(posedge clk_sys); n++; end while (wb_ack_o !== 1'b1 && n < 40);
      rv = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_sys);
   endtask
   task automatic cmd(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
      int n = 0;
      wb(1'b1, `BCP_OFS_CDB0, w0);
      wb(1'b1, `BCP_OFS_CDB1, w1);
      wb(1'b1, `BCP_OFS_CDB2, w2);
      st_seen = 1'b0;
      q = {};
      wb(1'b1, `BCP_OFS_CTRL, 32'h1);
      while (!st_seen && n < 400) begin @(posedge clk_sys); n++; end
      wb(1'b0, `BCP_OFS_STAT, 32'h0);
   endtask
   // control byte always zero
   task automatic ss(input logic im, input logic [3:0] pc, input logic lj, input logic sb);
      cmd({23'h0, im, 8'h1b}, {24'h0, pc, 2'b00, lj, sb}, 32'h0);
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      `CHK("ready", 1'b1, unit_ready);
      `CHK("power", 4'h1, power_cond);
      wb(1'b0, `BCP_OFS_BLK_LEN, 32'h0);
      `CHK("blklen", 32'h200, rv);
      wb(1'b0, 6'h3c, 32'h0);
      `CHK("unmapped", 32'h0, rv);
   endtask
   task automatic t_cap;
      wb(1'b1, `BCP_OFS_LAST_LBA, 32'ha13);
      wb(1'b1, `BCP_OFS_BLK_LEN, 32'h2);
      cmd(32'h25, 32'h0, 32'h0);
      `CHK("cap n", 8, q.size());
      `CHK("cap", 64'ha1300000002, {q[0], q[1], q[2], q[3], q[4], q[5], q[6], q[7]});
      `CHK("cap st", 32'h0, rv);
      medium_present <= 1'b0;
      repeat (3) @(posedge clk_sys);
      cmd(32'h25, 32'h0, 32'h0);
      `CHK("nomed", 32'h40202, rv);
      medium_present <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic t_read;
      cmd(32'h28, 32'h100a, 32'h2);
      `CHK("rd n", 4, q.size());
      `CHK("rd", 32'h10001101, {q[0], q[1], q[2], q[3]});
      `CHK("rd st", 32'h0, rv);
      cmd(32'h28, 32'h100a, 32'h0);
      `CHK("rd0", 32'h0, rv + q.size());
   endtask
   task automatic t_ss;
      ss(1'b0, 4'h0, 1'b1, 1'b0);
      `CHK("eject", {32'd1, 1'b0}, {ej, unit_ready});
      cmd(32'h28, 32'h0, 32'h0);
      `CHK("stopped", 32'h2040202, rv);
      ss(1'b0, 4'h0, 1'b1, 1'b1);
      `CHK("load", {32'd1, 1'b1}, {ld, unit_ready});
      ss(1'b0, 4'h0, 1'b0, 1'b0);
      `CHK("stop", {32'd1, 32'd1, 1'b0}, {ej, ld, unit_ready});
      ss(1'b0, 4'h0, 1'b0, 1'b1);
      `CHK("start", 1'b1, unit_ready);
   endtask
   task automatic t_power;
      logic [3:0]  pcs[6] = '{2, 3, 3, 4, 7, 1};
      logic [3:0]  pce[6] = '{2, 3, 3, 3, 7, 1};
      logic [31:0] sts[6] = '{0, 0, 0, 32'h240502, 0, 0};
      logic [31:0] rds[6] = '{0, 32'h5e0502, 32'h5e0502, 32'h5e0502, 0, 0};
      int f0, e0 = ej;
      for (int i = 0; i < 6; i++) begin
         f0 = fl;
         ss(1'b0, pcs[i], 1'b1, 1'b0);
         `CHK("pc st", sts[i], rv);
         `CHK("pc", pce[i], power_cond);
         `CHK("flush", int'(pcs[i] == 3), fl - f0);
         cmd(32'h28, 32'h0, 32'h0);
         `CHK("lp rd", rds[i], rv);
      end
      `CHK("ignored", e0, ej);
      f0 = fl;
      ss(1'b1, 4'h5, 1'b0, 1'b0);
      `CHK("early", {32'h0, f0}, {rv, fl});
      for (int n = 0; n < 60 && power_cond !== 4'h5; n++) @(posedge clk_sys);
      `CHK("sleep", {4'h5, f0 + 1}, {power_cond, fl});
      cmd(32'h25, 32'h0, 32'h0);
      `CHK("sleep cap", 32'h5e0502, rv);
      rst <= 1'b1;
      @(posedge clk_sys) rst <= 1'b0;
      @(posedge clk_sys);
      `CHK("reset", 4'h1, power_cond);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      t_regs();
      t_cap();
      t_read();
      t_ss();
      t_power();
      end_of_test();
   end
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end
endmodule // testbench
